// >>> hdl/adc_cycle_ctrl.sv
// Converter cycle sequencer, serial output, mux address port and register slave
// Notes on behaviour
// RL1: Mux code is the last four bits shifted in before mux select falls.
// RL2: Select high accepts address bits; falling select enables the chosen channel.
// RL3: An all-zero code keeps the previous channel.
// RL4: Serial output driven only while converter select is low.
// RL5: Cycle runs conversion, then sleep, then data output.
// RL6: Sleep lasts while converter select stays high.
// RL7: Rising converter select during output aborts and starts a conversion.
// RL8: During conversion and sleep the output shows conversion status.
// RL9: Output bits change only on falling serial clock edges.
// RL10: Host samples output bits on rising serial clock edges.
// RL11: Output ends after 24 bits or select high; then a conversion starts.
// RL12: Completed result held unchanged through sleep indefinitely.
// RL13: Host loads new code in sleep or at end of output.
// RL14: Each word belongs to the conversion just finished, no pipeline.
// RL15: Serial clock mode set by pin timing only, no configuration.
// RL16: Rate pin high selects 50 Hz timing, low selects 60 Hz.
// RL17: External clock on rate pin times conversions, word rate clock/20510.
// RL18: Power-up pulse clears state, then a conversion starts.
// RL19: No channel after power-up; first result flagged invalid.
// RL20: Host ties mux clock to serial clock, selects together, for four wires.
// RL21: Calibration runs every cycle without changing timing or interface.
// RL22: Result full scale reads FFFFF, zero scale reads 00000.
// RL23: Word is four status bits then 20 result bits, MSB first.
// RL24: Status: conversion busy, pad low, sign, range exceeded.
// RL25: Serial clock ignored by the shift register while select is high.
// RL26: 24th falling edge drives output high; extra clocks shift ones.
// RL27: Nonzero codes map to channels through a writable table.
`timescale 1ns/10ps
`default_nettype none
module adc_cycle_ctrl
  import adc_cycle_pkg::*;
#(
  parameter int POR_CYC    = adc_cycle_pkg::POR_CYCLES,
  parameter int CONV50_CYC = adc_cycle_pkg::CONV50_CYCLES,
  parameter int CONV60_CYC = adc_cycle_pkg::CONV60_CYCLES,
  parameter int EXT_DIV    = adc_cycle_pkg::EXT_WORD_DIV,
  parameter int EXT_IDLE   = adc_cycle_pkg::EXT_IDLE_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  // Wishbone slave
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [adc_cycle_pkg::ADR_BITS-1:0] wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic      [31:0]                       wb_dat_o,
  output logic                                   wb_ack_o,
  // Serial pins, asynchronous
  input  wire adc_cycle_pkg::pins_t              pins_i,
  output logic                                   sdo_o,
  output logic                                   sdo_oe_o,
  // Analog core
  input  wire adc_cycle_pkg::analog_t            analog_i,
  output logic                                   modulator_run_o,
  output logic [adc_cycle_pkg::NUM_CH-1:0]       analog_channel_sel_o
);
  import adc_cycle_pkg::*;

  // Input synchronisers; stage 3 only feeds edge detection
  pins_t sync1_q, sync2_q, sync3_q;
  // Edge detectors stay blind until stage 3 holds a real pin sample, so the
  // cleared chain never looks like an edge on a pin that idles high
  logic [2:0] warm_q, warm_d;
  assign warm_d = {warm_q[1:0], 1'b1};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      warm_q  <= '0;
    end else if (ce_i) begin
      sync1_q <= pins_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      warm_q  <= warm_d;
    end
  end

  logic sck_fall, mclk_rise, cs_rise, msel_fall, rate_edge, rate_rise;
  assign sck_fall  = warm_q[2] & sync3_q.sck & ~sync2_q.sck;
  assign mclk_rise = warm_q[2] & ~sync3_q.mux_clk & sync2_q.mux_clk;
  assign cs_rise   = warm_q[2] & ~sync3_q.conv_select_n & sync2_q.conv_select_n;
  assign msel_fall = warm_q[2] & sync3_q.mux_select_n & ~sync2_q.mux_select_n;
  assign rate_edge = warm_q[2] & (sync3_q.rate_select_in ^ sync2_q.rate_select_in);
  assign rate_rise = warm_q[2] & ~sync3_q.rate_select_in & sync2_q.rate_select_in;

  // Bus decode
  logic wb_req, wb_wr;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;

  // Code-to-channel table, one writable nibble per code
  logic [CODE_BITS-1:0] map_q [NUM_CODES];
  logic [CODE_BITS-1:0] map_d [NUM_CODES];

  for (genvar i = 0; i < NUM_CODES; i++) begin : g_map
    localparam logic [ADR_BITS-1:0] OFS = (i < 8) ? REG_MAP_LO : REG_MAP_HI;
    localparam logic [31:0] RST = (i < 8) ? MAP_LO_RST : MAP_HI_RST;
    localparam int POS = (i % 8) * 4;
    always_comb begin
      map_d[i] = map_q[i];
      if (wb_wr && wb_adr_i == OFS && wb_sel_i[POS/8]) begin
        map_d[i] = wb_dat_i[POS +: 4]; // RL27
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        map_q[i] <= RST[POS +: 4];
      end else if (ce_i) begin
        map_q[i] <= map_d[i];
      end
    end
  end

  // Sequencer state
  conv_state_t            state_q, state_d;
  logic [CNT_W-1:0]       cnt_q, cnt_d;
  logic [BIT_CNT_W-1:0]   bit_q, bit_d;
  logic [WORD_BITS-1:0]   shift_q, shift_d;
  logic [WORD_BITS-1:0]   result_q, result_d;
  logic                   sdo_d, sdo_oe_d, run_d;
  logic                   ext_q, ext_d;
  logic [IDLE_W-1:0]      idle_q, idle_d;
  logic                   inval_q, inval_d;
  logic [CODE_BITS-1:0]   msr_q, msr_d;
  logic [CODE_BITS-1:0]   code_q, code_d;
  logic                   chen_q, chen_d;
  logic [NUM_CH-1:0]      chsel_d;
  logic [CNT_W-1:0]       conv_last;
  logic                   tick;
  logic [CODE_BITS-1:0]   entry;

  // Conversion length follows the rate pin; an external clock is
  // recognised purely by edges arriving on it
  always_comb begin
    if (ext_q) begin
      conv_last = CNT_W'(EXT_DIV - 1); // RL17
    end else if (sync2_q.rate_select_in) begin
      conv_last = CNT_W'(CONV50_CYC - 1); // RL16
    end else begin
      conv_last = CNT_W'(CONV60_CYC - 1); // RL16
    end
    tick = ext_q ? rate_rise : 1'b1; // RL17
  end

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    bit_d    = bit_q;
    shift_d  = shift_q;
    result_d = result_q;
    inval_d  = inval_q;
    ext_d    = ext_q;
    idle_d   = idle_q;
    msr_d    = msr_q;
    code_d   = code_q;
    chen_d   = chen_q;

    if (rate_edge) begin
      ext_d  = 1'b1;
      idle_d = '0;
    end else if (idle_q == IDLE_W'(EXT_IDLE - 1)) begin
      ext_d = 1'b0;
    end else begin
      idle_d = idle_q + 1'b1;
    end

    unique case (state_q)
      ST_POR: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(POR_CYC - 1)) begin
          state_d = ST_CONV; // RL18
          cnt_d   = '0;
        end
      end
      ST_CONV: begin
        if (tick) begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q >= conv_last) begin
            // Core delivers calibrated, scaled data each cycle
            state_d = ST_SLEEP; // RL5 RL21
            shift_d = {1'b0, 1'b0, analog_i.sign_bit, analog_i.range_exceed_bit,
                       analog_i.result}; // RL23 RL24 RL22 RL14
            result_d = shift_d;
            inval_d  = ~chen_q; // RL19
          end
        end
      end
      ST_SLEEP: begin
        // Shift register untouched here, so the word waits as long as needed
        if (!sync2_q.conv_select_n) begin
          state_d = ST_OUT; // RL6 RL12
          bit_d   = '0;
        end
      end
      ST_OUT: begin
        if (cs_rise) begin
          state_d = ST_CONV; // RL7 RL11
          cnt_d   = '0;
        end else if (sck_fall && !sync2_q.conv_select_n) begin
          shift_d = {shift_q[WORD_BITS-2:0], 1'b1}; // RL9 RL25
          bit_d   = bit_q + 1'b1;
          if (bit_q == LAST_BIT) begin
            state_d = ST_CONV; // RL11 RL26
            cnt_d   = '0;
          end
        end
      end
    endcase

    // Busy reads high outside sleep/output, so extra clocks return ones
    if (state_d == ST_SLEEP || state_d == ST_OUT) begin
      sdo_d = shift_d[WORD_BITS-1]; // RL8
    end else begin
      sdo_d = 1'b1; // RL8 RL26
    end
    sdo_oe_d = ~sync2_q.conv_select_n; // RL4 RL15
    run_d    = (state_d == ST_CONV);

    if (sync2_q.mux_select_n && mclk_rise) begin
      msr_d = {msr_q[CODE_BITS-2:0], sync2_q.mux_din}; // RL1 RL2
    end
    if (msel_fall && msr_q != '0) begin
      code_d = msr_q; // RL1 RL3
      chen_d = 1'b1; // RL2
    end
    entry   = map_q[code_d];
    chsel_d = '0;
    if (chen_d && entry[MAP_VALID_BIT]) begin
      chsel_d[entry[CH_BITS-1:0]] = 1'b1; // RL2 RL27
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q              <= ST_POR;
      cnt_q                <= '0;
      bit_q                <= '0;
      shift_q              <= '0;
      result_q             <= '0;
      inval_q              <= 1'b1;
      ext_q                <= 1'b0;
      idle_q               <= '0;
      msr_q                <= '0;
      code_q               <= '0;
      chen_q               <= 1'b0;
      sdo_o                <= 1'b1;
      sdo_oe_o             <= 1'b0;
      modulator_run_o      <= 1'b0;
      analog_channel_sel_o <= '0;
    end else if (ce_i) begin
      state_q              <= state_d;
      cnt_q                <= cnt_d;
      bit_q                <= bit_d;
      shift_q              <= shift_d;
      result_q             <= result_d;
      inval_q              <= inval_d;
      ext_q                <= ext_d;
      idle_q               <= idle_d;
      msr_q                <= msr_d;
      code_q               <= code_d;
      chen_q               <= chen_d;
      sdo_o                <= sdo_d;
      sdo_oe_o             <= sdo_oe_d;
      modulator_run_o      <= run_d;
      analog_channel_sel_o <= chsel_d;
    end
  end

  // Register read and ack; unmapped reads return zero
  logic        ack_d;
  logic [31:0] dat_d;

  always_comb begin
    ack_d = wb_req;
    dat_d = '0;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_STATUS: begin
          dat_d[ST_STATE_LSB +: 2]         = state_q;
          dat_d[ST_EXT_BIT]                = ext_q;
          dat_d[ST_CHEN_BIT]               = chen_q;
          dat_d[ST_INVAL_BIT]              = inval_q;
          dat_d[ST_RATE_BIT]               = sync2_q.rate_select_in;
          dat_d[ST_CODE_LSB +: CODE_BITS]  = code_q;
        end
        REG_RESULT: dat_d[WORD_BITS-1:0] = result_q;
        REG_MAP_LO: begin
          for (int k = 0; k < 8; k++) begin
            dat_d[k*4 +: 4] = map_q[k];
          end
        end
        REG_MAP_HI: begin
          for (int k = 0; k < 8; k++) begin
            dat_d[k*4 +: 4] = map_q[k+8];
          end
        end
        default: dat_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= ack_d;
      wb_dat_o <= dat_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_OE_CS: assert property ( // RL4
    (ce_i && sync2_q.conv_select_n) |=> !sdo_oe_o)
    else $error("serial output enabled while converter select high");

  AST_SLEEP_NEXT: assert property ( // RL5
    state_q == ST_SLEEP |=> state_q inside {ST_SLEEP, ST_OUT})
    else $error("illegal exit from sleep");

  AST_SLEEP_HOLD: assert property ( // RL6
    (state_q == ST_SLEEP && sync2_q.conv_select_n) |=> state_q == ST_SLEEP)
    else $error("sleep left while select high");

  AST_ABORT: assert property ( // RL7
    (ce_i && state_q == ST_OUT && cs_rise) |=> state_q == ST_CONV && cnt_q == '0)
    else $error("rising select did not abort output");

  AST_SDO_FALL: assert property ( // RL9
    (state_q == ST_OUT && $past(state_q) == ST_OUT && $changed(shift_q))
      |-> $past(sck_fall))
    else $error("output shifted without falling clock");

  AST_WORD_END: assert property ( // RL26
    (ce_i && state_q == ST_OUT && bit_q == LAST_BIT && sck_fall
      && !cs_rise && !sync2_q.conv_select_n) |=> state_q == ST_CONV ##1 sdo_o)
    else $error("24th edge did not start conversion with output high");

  AST_ZERO_CODE: assert property ( // RL3
    (ce_i && msel_fall && msr_q == '0) |=> $stable(code_q))
    else $error("zero code changed the channel");

  AST_CODE_LOAD: assert property ( // RL1
    (ce_i && msel_fall && msr_q != '0) |=> code_q == $past(msr_q) && chen_q)
    else $error("channel code not taken on select fall");

  AST_HOLD_RESULT: assert property ( // RL12
    (state_q == ST_SLEEP && $past(state_q) == ST_SLEEP) |-> $stable(shift_q))
    else $error("held result changed during sleep");

  AST_BUSY_HIGH: assert property ( // RL8
    (state_q == ST_CONV && $past(state_q) == ST_CONV) |-> sdo_o)
    else $error("status not high during conversion");

  COV_FULL_WORD: cover property (state_q == ST_OUT && bit_q == LAST_BIT && sck_fall);
  COV_ABORT:     cover property (state_q == ST_OUT && cs_rise);
  COV_CHANNEL:   cover property ($rose(chen_q));
  COV_EXT_CLK:   cover property ($rose(ext_q));
endmodule
`default_nettype wire

// >>> shared/adc_cycle_pkg.sv
// Constants, types and register map for the converter cycle controller
package adc_cycle_pkg;
  localparam int WORD_BITS   = 24;
  localparam int RESULT_BITS = 20;
  localparam int CODE_BITS   = 4;
  localparam int NUM_CODES   = 16;
  localparam int NUM_CH      = 8;
  localparam int CH_BITS     = 3;
  localparam int BIT_CNT_W   = 5;
  localparam int CNT_W       = 25;
  localparam int IDLE_W      = 17;
  localparam int ADR_BITS    = 8;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h17;

  // Timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int POR_TIME_NS     = 500_000;
  localparam int POR_CYCLES      = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV50_TIME_NS  = 160_230_000;
  localparam int CONV50_CYCLES   = CONV50_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV60_TIME_NS  = 133_530_000;
  localparam int CONV60_CYCLES   = CONV60_TIME_NS / CLK_PERIOD_NS;
  localparam int EXT_WORD_DIV    = 20510;
  localparam int EXT_NOTCH_DIV   = 2560;
  localparam int EXT_IDLE_NS     = 1_000_000;
  localparam int EXT_IDLE_CYCLES = EXT_IDLE_NS / CLK_PERIOD_NS;

  // Register offsets (byte addresses)
  localparam logic [ADR_BITS-1:0] REG_STATUS = 8'h00;
  localparam logic [ADR_BITS-1:0] REG_RESULT = 8'h04;
  localparam logic [ADR_BITS-1:0] REG_MAP_LO = 8'h08;
  localparam logic [ADR_BITS-1:0] REG_MAP_HI = 8'h0C;

  // Status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_EXT_BIT   = 2;
  localparam int ST_CHEN_BIT  = 3;
  localparam int ST_INVAL_BIT = 4;
  localparam int ST_RATE_BIT  = 5;
  localparam int ST_CODE_LSB  = 8;

  // Map entry: bit 3 valid, bits 2:0 channel index
  localparam int MAP_VALID_BIT = 3;
  localparam logic [31:0] MAP_LO_RST = 32'h0000_0000;
  localparam logic [31:0] MAP_HI_RST = 32'hFEDC_BA98;

  typedef enum logic [1:0] {ST_POR, ST_CONV, ST_SLEEP, ST_OUT} conv_state_t;

  typedef struct packed {
    logic sck;
    logic mux_clk;
    logic mux_din;
    logic conv_select_n;
    logic mux_select_n;
    logic rate_select_in;
  } pins_t;

  typedef struct packed {
    logic [RESULT_BITS-1:0] result;
    logic                   sign_bit;
    logic                   range_exceed_bit;
  } analog_t;
endpackage

// >>> tb/serial_host_model.sv
// Host serial master model: four-wire mux load, result read and status poll
`timescale 1ns/10ps
`default_nettype none
module serial_host_model
  import adc_cycle_pkg::*;
#(
  parameter int HALF = 6
) (
  // Clock and rate pin level
  input  wire logic           clk_i,
  input  wire logic           rate_i,
  // Converter side
  input  wire logic           sdo_i,
  input  wire logic           sdo_oe_i,
  output var adc_cycle_pkg::pins_t pins_o
);
  pins_t p_q    = 6'b000110;
  logic  last_q = 1'b0;
  logic  line;
  // A released line shows the inverse of its last bit, never a stale copy
  assign line = sdo_oe_i ? sdo_i : ~last_q;
  always_ff @(posedge clk_i) begin
    if (sdo_oe_i) begin
      last_q <= sdo_i;
    end
  end
  always_comb begin
    pins_o = p_q;
    pins_o.rate_select_in = rate_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Shift clocks tied for four-wire use
  task automatic clk_pair(input logic v);
    p_q.sck <= v;
    p_q.mux_clk <= v;
  endtask
  // Caller enters right after a clock edge, while the converter sleeps
  task automatic frame(input logic [5:0] mux, input int nbits, output logic [25:0] w);
    w = '0;
    for (int i = 5; i >= 0; i--) begin
      p_q.mux_din <= mux[i];
      tick(HALF);
      clk_pair(1'b1);
      tick(HALF);
      clk_pair(1'b0);
    end
    tick(HALF);
    p_q.mux_select_n <= 1'b0;
    p_q.conv_select_n <= 1'b0;
    tick(HALF);
    for (int i = 0; i < nbits; i++) begin
      clk_pair(1'b1);
      w = {w[24:0], line};
      tick(HALF);
      clk_pair(1'b0);
      tick(HALF);
    end
    p_q.mux_select_n <= 1'b1;
    p_q.conv_select_n <= 1'b1;
    tick(1);
  endtask
  task automatic poll(output logic b);
    p_q.conv_select_n <= 1'b0;
    tick(HALF);
    b = line;
    p_q.conv_select_n <= 1'b1;
    tick(1);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the converter cycle controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  import adc_cycle_pkg::*;
  typedef struct packed {
    logic [5:0] mux;
    logic [7:0] sel;
    analog_t    ana;
  } row_t;
  // Mux bits shifted, expected channel enable, analog value for next conversion
  localparam row_t ROWS [5] = '{
    {6'h3B, 8'h08, 20'hFFFFF, 1'b1, 1'b0},
    {6'h30, 8'h08, 20'h00000, 1'b0, 1'b0},
    {6'h08, 8'h01, 20'hA5C3E, 1'b1, 1'b1},
    {6'h0F, 8'h80, 20'h12345, 1'b0, 1'b1},
    {6'h01, 8'h20, 20'h5A5A5, 1'b1, 1'b0}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        rate = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic        ack;
  pins_t       pins;
  logic        sdo;
  logic        sdo_oe;
  analog_t     ana = '0;
  logic        run;
  logic [7:0]  ch_sel;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  adc_cycle_ctrl #(.POR_CYC(20), .CONV50_CYC(200), .CONV60_CYC(200), .EXT_DIV(8),
    .EXT_IDLE(50)) adc_cycle_ctrl_i (.clk_i(clk), .rst_i(rst), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .pins_i(pins), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .analog_i(ana), .modulator_run_o(run),
    .analog_channel_sel_o(ch_sel));
  serial_host_model host_i (.clk_i(clk), .rate_i(rate), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
    .pins_o(pins));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic test_done();
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic cycle: hold the request until ack is sampled, then release
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                         input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = dat_r;
    if (n >= 100) fail_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_run(input logic lvl, input int lim);
    int n;
    n = 0;
    while (run !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    logic [25:0] w;
    logic [31:0] q;
    logic [31:0] exp;
    logic        b;
    logic        have;
    have = 1'b0;
    exp = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    check({sdo_oe, ack, run, ch_sel}, 32'h0);
    @(posedge clk);
    wb_xfer(1'b0, REG_MAP_HI, 4'h0, 32'h0, q);
    check(q, MAP_HI_RST);
    wb_xfer(1'b0, REG_MAP_LO, 4'h0, 32'h0, q);
    check(q, MAP_LO_RST);
    wb_xfer(1'b0, 8'h10, 4'h0, 32'h0, q);
    check(q, 32'h0);
    wait_run(1'b1, 100);
    check(run, 1'b1);
    wait_run(1'b0, 400);
    check(run, 1'b0);
    wb_xfer(1'b0, REG_STATUS, 4'h0, 32'h0, q);
    check(q & 32'h3F, 32'h32);
    check({sdo_oe, ch_sel}, 32'h0);
    // Only lane 0 may land: code 1 goes to channel 5
    wb_xfer(1'b1, REG_MAP_LO, 4'h1, 32'hFFFF_FFD0, q);
    wb_xfer(1'b0, REG_MAP_LO, 4'h0, 32'h0, q);
    check(q, 32'h0000_00D0);
    for (int i = 0; i < 5; i++) begin
      if (have) begin
        wb_xfer(1'b0, REG_RESULT, 4'h0, 32'h0, q);
        check(q, exp);
      end
      host_i.frame(ROWS[i].mux, 26, w);
      if (have) check({6'h0, w}, {exp[23:0], 2'b11});
      check(ch_sel, ROWS[i].sel);
      check(run, 1'b1);
      host_i.poll(b);
      check(b, 1'b1);
      ana <= ROWS[i].ana;
      exp = {10'h0, ROWS[i].ana.sign_bit, ROWS[i].ana.range_exceed_bit, ROWS[i].ana.result};
      have = 1'b1;
      wait_run(1'b0, 400);
      check(run, 1'b0);
    end
    // Abort after five bits, then a long sleep before the next read
    host_i.frame(6'h00, 5, w);
    wait_run(1'b1, 10);
    check(run, 1'b1);
    repeat (4) @(posedge clk);
    check(sdo_oe, 1'b0);
    ana <= {20'h0F0F0, 1'b0, 1'b1};
    wait_run(1'b0, 400);
    repeat (3000) @(posedge clk);
    host_i.frame(6'h00, 26, w);
    check({6'h0, w}, {6'h0, 4'b0001, 20'h0F0F0, 2'b11});
    check(ch_sel, 8'h20);
    // Frozen enable must hold the conversion well past its length
    ce <= 1'b0;
    repeat (300) @(posedge clk);
    check(run, 1'b1);
    ce <= 1'b1;
    // Any edge on the rate pin switches to external timing
    rate <= 1'b0;
    repeat (8) @(posedge clk);
    wb_xfer(1'b0, REG_STATUS, 4'h0, 32'h0, q);
    check(q & 32'h24, 32'h04);
    test_done();
  end
endmodule
`default_nettype wire
